/* File: rtl/rtc_alarm_params.svh */
// register offsets, field positions, reset values for the alarm and time-stamp block
// assumes inclusion by bare name from the rtl folder
`ifndef RTC_ALARM_PARAMS_SVH
`define RTC_ALARM_PARAMS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define OFS_A0_SEC        8'h0c
`define OFS_A0_MIN        8'h0d
`define OFS_A0_HOUR       8'h0e
`define OFS_A0_DAY        8'h0f
`define OFS_A0_DATE       8'h10
`define OFS_A0_MONTH      8'h11
`define OFS_A1_SUBSEC     8'h12
`define OFS_A1_SEC        8'h13
`define OFS_A1_MIN        8'h14
`define OFS_A1_HOUR       8'h15
`define OFS_A1_DAY        8'h16
`define OFS_A1_DATE       8'h17
`define OFS_PD_MIN        8'h18
`define OFS_PD_HOUR       8'h19
`define OFS_PD_DATE       8'h1a
`define OFS_PD_MONTH      8'h1b
`define OFS_PU_MIN        8'h1c
`define OFS_PU_HOUR       8'h1d
`define OFS_PU_DATE       8'h1e
`define OFS_PU_MONTH      8'h1f

// ----------------------------------------
// field masks and positions
// ----------------------------------------
`define MASK_SEC          8'h7f
`define MASK_MIN          8'h7f
`define MASK_HOUR         8'h3f
`define MASK_DATE         8'h3f
`define MASK_MONTH        8'h1f
`define MASK_WDAY         8'h07
`define HOUR_FMT_BIT      6
`define DAY_FLAG_BIT      3
`define ENA_A0_BIT        0
`define ENA_A1_BIT        1

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define RST_BYTE          8'h00
`define RST_COND          3'h0
`define MIDNIGHT_HOUR_24  8'h00
`define MIDNIGHT_HOUR_12  8'h12
`define ZERO_BCD          8'h00

`endif

/* File: rtl/rtc_alarm_pkg.sv */
// types shared by the alarm and time-stamp block
// assumes nothing of its surroundings
package rtc_alarm_pkg;

   typedef enum logic [2:0] {
      COND_SEC    = 3'h0,
      COND_MIN    = 3'h1,
      COND_HOUR   = 3'h2,
      COND_WDAY   = 3'h3,
      COND_DATE   = 3'h4,
      COND_RSV5   = 3'h5,
      COND_RSV6   = 3'h6,
      COND_ALL    = 3'h7
   } alarm_cond_e;

   typedef logic [7:0] byte_t;

endpackage : rtc_alarm_pkg

/* File: rtl/rtc_alarm_regs.sv */
// alarm match and power-fail time-stamp registers of a real-time clock calendar
// assumes the serial front end gives one-cycle rd/wr strobes with an 8-bit address,
// and the timekeeping core gives BCD calendar fields plus a pulse per field update
//
// Function
// (RL1) first alarm format bit mirrors main format
// (RL2) codes 000/001/100 match seconds, minutes, date
// (RL3) code 010 matches hours in effective format
// (RL4) code 011 weekday match fires at midnight
// (RL5) host never programs codes 101 or 110
// (RL6) code 111 needs all six fields matching
// (RL7) match sets alarm flag at bit three
// (RL8) flag sticks until software writes clear
// (RL9) second alarm owns condition field and flag
// (RL10) month match only on first alarm
// (RL11) second alarm compares tenths and hundredths
// (RL12) weekday field holds one through seven
// (RL13) unimplemented bits read as zero
// (RL14) stamp hours capture format bit at event
// (RL15) power-down bank with weekday in month
// (RL16) power-up bank with same layout
// (RL17) host uses stamps only with oscillator running
// (RL18) hour bits five four: tens or pm
// (RL19) format bit zero 24h, one 12h
// (RL20) enable field selects none, first, second, both
// (RL21) capture once at supply loss and return
// (RL22) evaluate once per counter field update
`timescale 1ns/1ps
`include "rtc_alarm_params.svh"

module rtc_alarm_regs (
   input  wire logic        clk_sys_in,     // system clock, 10 MHz
   input  wire logic        rst_in,         // sync reset, high
   input  wire logic        ce_in,          // clock enable, freezes all state
   input  wire logic [7:0]  addr_in,        // register address
   input  wire logic        wr_in,          // write strobe, one cycle
   input  wire logic [7:0]  wdata_in,       // write data
   input  wire logic        rd_in,          // read strobe, one cycle
   output logic      [7:0]  rdata_out,      // read data, valid cycle after rd_in
   output logic             rvalid_out,     // read data valid pulse
   input  wire logic [1:0]  alarm_enable_field_in, // control alarm enable bits
   input  wire logic [7:0]  cal_subsec_in,  // live tenths/hundredths BCD
   input  wire logic [7:0]  cal_sec_in,     // live seconds BCD
   input  wire logic [7:0]  cal_min_in,     // live minutes BCD
   input  wire logic [7:0]  cal_hour_in,    // live hours incl format bit 6
   input  wire logic [2:0]  cal_wday_in,    // live weekday
   input  wire logic [7:0]  cal_date_in,    // live date BCD
   input  wire logic [7:0]  cal_month_in,   // live month BCD
   input  wire logic        subsec_tick_in, // sub-second field updated
   input  wire logic        sec_tick_in,    // seconds field updated
   input  wire logic        supply_fail_in, // main supply failed, switched to backup
   output logic             first_alarm_flag_out,  // first alarm flag
   output logic             second_alarm_flag_out  // second alarm flag
);

   // ----------------------------------------
   // alarm storage
   // ----------------------------------------
   logic [7:0] a0_sec_q, a0_min_q, a0_hour_q, a0_wday_q, a0_date_q, a0_month_q;
   logic [7:0] a1_subsec_q, a1_sec_q, a1_min_q, a1_hour_q, a1_wday_q, a1_date_q;
   logic [2:0] first_alarm_condition_q;
   logic [2:0] second_alarm_condition_q;
   logic       first_alarm_flag_q;
   logic       second_alarm_flag_q;
   logic       supply_fail_q;
   logic [7:0] rdata_q;
   logic       rvalid_q;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire w_a0_sec    = wr_in && (addr_in == `OFS_A0_SEC);
   wire w_a0_min    = wr_in && (addr_in == `OFS_A0_MIN);
   wire w_a0_hour   = wr_in && (addr_in == `OFS_A0_HOUR);
   wire w_a0_day    = wr_in && (addr_in == `OFS_A0_DAY);
   wire w_a0_date   = wr_in && (addr_in == `OFS_A0_DATE);
   wire w_a0_month  = wr_in && (addr_in == `OFS_A0_MONTH);
   wire w_a1_subsec = wr_in && (addr_in == `OFS_A1_SUBSEC);
   wire w_a1_sec    = wr_in && (addr_in == `OFS_A1_SEC);
   wire w_a1_min    = wr_in && (addr_in == `OFS_A1_MIN);
   wire w_a1_hour   = wr_in && (addr_in == `OFS_A1_HOUR);
   wire w_a1_day    = wr_in && (addr_in == `OFS_A1_DAY);
   wire w_a1_date   = wr_in && (addr_in == `OFS_A1_DATE);
   wire pd_hit      = (addr_in >= `OFS_PD_MIN) && (addr_in <= `OFS_PD_MONTH);
   wire pu_hit      = (addr_in >= `OFS_PU_MIN) && (addr_in <= `OFS_PU_MONTH);

   // ----------------------------------------
   // match logic
   // ----------------------------------------
   // 12h hour values compare on bits 5:0 only, pm bit included and format bit 6 left out, so the
   // alarm's hour is meaningful only in the format currently in effect
   function automatic logic hour_eq(input logic [7:0] a, input logic [7:0] live);
      hour_eq = ((a & `MASK_HOUR) == (live & `MASK_HOUR));        // [RL3] [RL18]
   endfunction : hour_eq

   function automatic logic at_midnight(input logic [7:0] live_hour, input logic [7:0] sec,
                                        input logic [7:0] min);
      logic [7:0] mid;
      mid = live_hour[`HOUR_FMT_BIT] ? `MIDNIGHT_HOUR_12 : `MIDNIGHT_HOUR_24;   // [RL19]
      at_midnight = ((live_hour & `MASK_HOUR) == mid) && ((sec & `MASK_SEC) == `ZERO_BCD)
                    && ((min & `MASK_MIN) == `ZERO_BCD);
   endfunction : at_midnight

   function automatic logic cond_hit(input logic [2:0] c, input logic s, input logic m,
                                     input logic h, input logic w, input logic d,
                                     input logic mo, input logic mid);
      case (rtc_alarm_pkg::alarm_cond_e'(c))
         rtc_alarm_pkg::COND_SEC:  cond_hit = s;                  // [RL2]
         rtc_alarm_pkg::COND_MIN:  cond_hit = m;                  // [RL2]
         rtc_alarm_pkg::COND_HOUR: cond_hit = h;                  // [RL3]
         rtc_alarm_pkg::COND_WDAY: cond_hit = w && mid;           // [RL4]
         rtc_alarm_pkg::COND_DATE: cond_hit = d;                  // [RL2]
         rtc_alarm_pkg::COND_ALL:  cond_hit = s && m && h && w && d && mo;   // [RL6]
         default:                  cond_hit = 1'b0;               // [RL5]
      endcase
   endfunction : cond_hit

   wire s0  = (a0_sec_q & `MASK_SEC) == (cal_sec_in & `MASK_SEC);
   wire m0  = (a0_min_q & `MASK_MIN) == (cal_min_in & `MASK_MIN);
   wire h0  = hour_eq(a0_hour_q, cal_hour_in);
   wire w0  = a0_wday_q[2:0] == cal_wday_in;
   wire d0  = (a0_date_q & `MASK_DATE) == (cal_date_in & `MASK_DATE);
   wire mo0 = (a0_month_q & `MASK_MONTH) == (cal_month_in & `MASK_MONTH);   // [RL10]
   wire s1  = (a1_sec_q & `MASK_SEC) == (cal_sec_in & `MASK_SEC);
   wire m1  = (a1_min_q & `MASK_MIN) == (cal_min_in & `MASK_MIN);
   wire h1  = hour_eq(a1_hour_q, cal_hour_in);
   wire w1  = a1_wday_q[2:0] == cal_wday_in;
   wire d1  = (a1_date_q & `MASK_DATE) == (cal_date_in & `MASK_DATE);
   wire ss1 = a1_subsec_q == cal_subsec_in;                       // [RL11]
   wire mid = at_midnight(cal_hour_in, cal_sec_in, cal_min_in);

   // first alarm evaluates on each seconds update; second on each sub-second
   // update, so a match holding for a whole second still sets only once
   wire hit0 = sec_tick_in && alarm_enable_field_in[`ENA_A0_BIT]                       // [RL20] [RL22]
               && cond_hit(first_alarm_condition_q, s0, m0, h0, w0, d0, mo0, mid);
   // second alarm has no month compare; every mode also needs the sub-seconds to match
   wire hit1 = subsec_tick_in && alarm_enable_field_in[`ENA_A1_BIT] && ss1             // [RL20] [RL22] [RL11]
               && cond_hit(second_alarm_condition_q, s1, m1, h1, w1, d1, 1'b1, mid);   // [RL9] [RL10]

   // ----------------------------------------
   // alarm registers
   // ----------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         a0_sec_q    <= `RST_BYTE;
         a0_min_q    <= `RST_BYTE;
         a0_hour_q   <= `RST_BYTE;
         a0_wday_q   <= `RST_BYTE;
         a0_date_q   <= `RST_BYTE;
         a0_month_q  <= `RST_BYTE;
         a1_subsec_q <= `RST_BYTE;
         a1_sec_q    <= `RST_BYTE;
         a1_min_q    <= `RST_BYTE;
         a1_hour_q   <= `RST_BYTE;
         a1_wday_q   <= `RST_BYTE;
         a1_date_q   <= `RST_BYTE;
         first_alarm_condition_q  <= `RST_COND;
         second_alarm_condition_q <= `RST_COND;
      end else if (ce_in) begin
         if (w_a0_sec)    a0_sec_q    <= wdata_in & `MASK_SEC;
         if (w_a0_min)    a0_min_q    <= wdata_in & `MASK_MIN;
         if (w_a0_hour)   a0_hour_q   <= wdata_in & `MASK_HOUR;    // [RL1]
         if (w_a0_day)    a0_wday_q   <= wdata_in & `MASK_WDAY;    // [RL12]
         if (w_a0_day)    first_alarm_condition_q <= wdata_in[6:4];
         if (w_a0_date)   a0_date_q   <= wdata_in & `MASK_DATE;
         if (w_a0_month)  a0_month_q  <= wdata_in & `MASK_MONTH;
         if (w_a1_subsec) a1_subsec_q <= wdata_in;
         if (w_a1_sec)    a1_sec_q    <= wdata_in & `MASK_SEC;
         if (w_a1_min)    a1_min_q    <= wdata_in & `MASK_MIN;
         if (w_a1_hour)   a1_hour_q   <= wdata_in & (`MASK_HOUR | 8'h40);
         if (w_a1_day)    a1_wday_q   <= wdata_in & `MASK_WDAY;    // [RL12]
         if (w_a1_day)    second_alarm_condition_q <= wdata_in[6:4];   // [RL9]
         if (w_a1_date)   a1_date_q   <= wdata_in & `MASK_DATE;
      end
   end

   // ----------------------------------------
   // sticky flags: a match in the clearing cycle keeps the flag set
   // ----------------------------------------
   wire clr0 = w_a0_day && !wdata_in[`DAY_FLAG_BIT];
   wire clr1 = w_a1_day && !wdata_in[`DAY_FLAG_BIT];

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         first_alarm_flag_q  <= 1'b0;
         second_alarm_flag_q <= 1'b0;
      end else if (ce_in) begin
         if (hit0)      first_alarm_flag_q <= 1'b1;                // [RL7]
         else if (clr0) first_alarm_flag_q <= 1'b0;                // [RL8]
         if (hit1)      second_alarm_flag_q <= 1'b1;               // [RL7] [RL9]
         else if (clr1) second_alarm_flag_q <= 1'b0;               // [RL8]
      end
   end

   assign first_alarm_flag_out  = first_alarm_flag_q;
   assign second_alarm_flag_out = second_alarm_flag_q;

   // ----------------------------------------
   // power event detection and stamp banks
   // ----------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) supply_fail_q <= 1'b0;
      else if (ce_in) supply_fail_q <= supply_fail_in;
   end

   wire pd_capture = supply_fail_in && !supply_fail_q;            // [RL21]
   wire pu_capture = !supply_fail_in && supply_fail_q;            // [RL21]
   wire [7:0] pd_rdata;
   wire [7:0] pu_rdata;

   stamp_bank u_powerdown (
      .clk_sys_in   (clk_sys_in),
      .rst_in       (rst_in),
      .ce_in        (ce_in),
      .capture_in   (pd_capture),
      .cal_min_in   (cal_min_in),
      .cal_hour_in  (cal_hour_in),
      .cal_date_in  (cal_date_in),
      .cal_month_in (cal_month_in),
      .cal_wday_in  (cal_wday_in),
      .wr_sel_in    (addr_in[1:0]),
      .wr_in        (wr_in && pd_hit),
      .wdata_in     (wdata_in),
      .rd_sel_in    (addr_in[1:0]),
      .rdata_out    (pd_rdata)
   );

   stamp_bank u_powerup (
      .clk_sys_in   (clk_sys_in),
      .rst_in       (rst_in),
      .ce_in        (ce_in),
      .capture_in   (pu_capture),
      .cal_min_in   (cal_min_in),
      .cal_hour_in  (cal_hour_in),
      .cal_date_in  (cal_date_in),
      .cal_month_in (cal_month_in),
      .cal_wday_in  (cal_wday_in),
      .wr_sel_in    (addr_in[1:0]),
      .wr_in        (wr_in && pu_hit),
      .wdata_in     (wdata_in),
      .rd_sel_in    (addr_in[1:0]),
      .rdata_out    (pu_rdata)
   );

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // stamp banks answer from their own output register, so their address
   // is held one cycle in sel_stamp to pick the bank at the answer
   logic [1:0] sel_stamp_q;
   wire [7:0] day0_rd = {1'b0, first_alarm_condition_q, first_alarm_flag_q, a0_wday_q[2:0]};
   wire [7:0] day1_rd = {1'b0, second_alarm_condition_q, second_alarm_flag_q, a1_wday_q[2:0]};
   wire [7:0] hour0_rd = (a0_hour_q & `MASK_HOUR) | {1'b0, cal_hour_in[`HOUR_FMT_BIT], 6'h00};  // [RL1]
   wire [7:0] alarm_rd =
      (addr_in == `OFS_A0_SEC)    ? a0_sec_q :
      (addr_in == `OFS_A0_MIN)    ? a0_min_q :
      (addr_in == `OFS_A0_HOUR)   ? hour0_rd :
      (addr_in == `OFS_A0_DAY)    ? day0_rd :
      (addr_in == `OFS_A0_DATE)   ? a0_date_q :
      (addr_in == `OFS_A0_MONTH)  ? a0_month_q :
      (addr_in == `OFS_A1_SUBSEC) ? a1_subsec_q :
      (addr_in == `OFS_A1_SEC)    ? a1_sec_q :
      (addr_in == `OFS_A1_MIN)    ? a1_min_q :
      (addr_in == `OFS_A1_HOUR)   ? a1_hour_q :
      (addr_in == `OFS_A1_DAY)    ? day1_rd :
      (addr_in == `OFS_A1_DATE)   ? a1_date_q : `RST_BYTE;       // [RL13]

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rdata_q     <= `RST_BYTE;
         rvalid_q    <= 1'b0;
         sel_stamp_q <= 2'h0;
      end else if (ce_in) begin
         rvalid_q    <= rd_in;
         sel_stamp_q <= {pu_hit, pd_hit};
         if (rd_in) rdata_q <= alarm_rd;
      end
   end

   assign rdata_out  = sel_stamp_q[0] ? pd_rdata : sel_stamp_q[1] ? pu_rdata : rdata_q;
   assign rvalid_out = rvalid_q;

endmodule : rtc_alarm_regs

/* File: rtl/stamp_bank.sv */
// one time-stamp bank: minutes, hours, date, weekday and month captured on a power event
// assumes capture pulse and host writes are synchronous to clk_sys_in
`timescale 1ns/1ps
`include "rtc_alarm_params.svh"

module stamp_bank (
   input  wire logic       clk_sys_in,    // system clock
   input  wire logic       rst_in,        // sync reset, high
   input  wire logic       ce_in,         // clock enable
   input  wire logic       capture_in,    // one-cycle power event
   input  wire logic [7:0] cal_min_in,    // live minutes
   input  wire logic [7:0] cal_hour_in,   // live hours incl format bit
   input  wire logic [7:0] cal_date_in,   // live date
   input  wire logic [7:0] cal_month_in,  // live month
   input  wire logic [2:0] cal_wday_in,   // live weekday
   input  wire logic [1:0] wr_sel_in,     // register written: 0 min 1 hour 2 date 3 month
   input  wire logic       wr_in,         // host write strobe
   input  wire logic [7:0] wdata_in,      // host write data
   input  wire logic [1:0] rd_sel_in,     // register read select
   output logic      [7:0] rdata_out      // registered read data
);

   logic [7:0] min_q;
   logic [7:0] hour_q;
   logic [7:0] date_q;
   logic [7:0] month_q;
   logic [7:0] rd_mux;

   // capture wins over a host write in the same cycle
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         min_q   <= `RST_BYTE;
         hour_q  <= `RST_BYTE;
         date_q  <= `RST_BYTE;
         month_q <= `RST_BYTE;
      end else if (ce_in) begin
         if (capture_in) begin
            min_q   <= cal_min_in & `MASK_MIN;                  // [RL15] [RL16] [RL21]
            hour_q  <= cal_hour_in & (`MASK_HOUR | 8'h40);      // [RL14]
            date_q  <= cal_date_in & `MASK_DATE;
            month_q <= {cal_wday_in, cal_month_in[4:0]};        // [RL15]
         end else if (wr_in) begin
            if (wr_sel_in == 2'h0) min_q <= wdata_in & `MASK_MIN;
            if (wr_sel_in == 2'h1) hour_q <= wdata_in & (`MASK_HOUR | 8'h40);
            if (wr_sel_in == 2'h2) date_q <= wdata_in & `MASK_DATE;
            if (wr_sel_in == 2'h3) month_q <= wdata_in;
         end
      end
   end

   assign rd_mux = (rd_sel_in == 2'h0) ? min_q :
                   (rd_sel_in == 2'h1) ? hour_q :
                   (rd_sel_in == 2'h2) ? date_q : month_q;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) rdata_out <= `RST_BYTE;
      else if (ce_in) rdata_out <= rd_mux;
   end

endmodule : stamp_bank

/* File: tb/host_model.sv */
// host side of the register strobe bus: write and read tasks
// assumes read data comes with rvalid one cycle after the strobe
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk_sys_in, // system clock
   input  wire logic [7:0] rdata_in,   // read data
   input  wire logic       rvalid_in,  // read valid
   output logic      [7:0] addr_out,   // address
   output logic            wr_out,     // write strobe
   output logic      [7:0] wdata_out,  // write data
   output logic            rd_out      // read strobe
);
   initial {addr_out, wr_out, wdata_out, rd_out} = '0;
   // never issues condition codes 101/110; flags cleared only by an explicit write
   task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys_in);
      addr_out <= a;
      wdata_out <= v;
      wr_out <= 1'b1;
      @(posedge clk_sys_in);
      wr_out <= 1'b0;
   endtask : write_reg
   // address held after the read: stamp data follow it
   task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_sys_in);
      rd_out <= 1'b0;
      v = 8'hxx;
      for (int i = 0; i < 3; i++) begin
         #1;
         if (rvalid_in === 1'b1) begin
            v = rdata_in;
            break;
         end
         @(posedge clk_sys_in);
      end
   endtask : read_reg
endmodule : host_model

/* File: tb/rtc_alarm_regs_sva.sv */
// concurrent checks on the alarm and time-stamp register block
// assumes it is bound to rtc_alarm_regs and sees only its ports
`timescale 1ns/1ps
module rtc_alarm_regs_chk (
   input  wire logic       clk_sys_in,            // clock
   input  wire logic       rst_in,                // sync reset
   input  wire logic       ce_in,                 // clock enable
   input  wire logic [7:0] addr_in,               // address
   input  wire logic       wr_in,                 // write strobe
   input  wire logic [7:0] wdata_in,              // write data
   input  wire logic       rd_in,                 // read strobe
   input  wire logic [7:0] rdata_out,             // read data
   input  wire logic       rvalid_out,            // read valid
   input  wire logic [1:0] alarm_enable_field_in, // alarm enables
   input  wire logic [7:0] cal_hour_in,           // live hours
   input  wire logic       subsec_tick_in,        // sub-second tick
   input  wire logic       sec_tick_in,           // seconds tick
   input  wire logic       first_alarm_flag_out,  // first flag
   input  wire logic       second_alarm_flag_out  // second flag
);
   // ----------------------------------------
   // clear strobes and read steps
   // ----------------------------------------
   wire clr0 = ce_in && wr_in && addr_in == 8'h0f && !wdata_in[3];
   wire clr1 = ce_in && wr_in && addr_in == 8'h16 && !wdata_in[3];
   wire unm  = ce_in && rd_in && (addr_in < 8'h0c || addr_in > 8'h1f);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   sequence s_rd(a);
      ce_in && rd_in && addr_in == a;
   endsequence
   chk_flag0_holds: assert property (first_alarm_flag_out && !clr0 |=> first_alarm_flag_out)
      else $error("first flag dropped without clear");
   chk_flag1_holds: assert property (second_alarm_flag_out && !clr1 |=> second_alarm_flag_out)
      else $error("second flag dropped without clear");
   chk_flag0_cause: assert property (!first_alarm_flag_out && !(ce_in && sec_tick_in && alarm_enable_field_in[0])
      |=> !first_alarm_flag_out)
      else $error("first flag set without enabled tick");
   chk_flag1_cause: assert property (!second_alarm_flag_out && !(ce_in && subsec_tick_in && alarm_enable_field_in[1])
      |=> !second_alarm_flag_out)
      else $error("second flag set without enabled tick");
   chk_read_answer: assert property (ce_in |=> rvalid_out == $past(rd_in))
      else $error("read valid not one cycle after strobe");
   chk_hour_mirror: assert property (s_rd(8'h0e) |=> rdata_out[7:6] == {1'b0, $past(cal_hour_in[6])})
      else $error("alarm hour format bit not live");
   chk_day0_flag: assert property (s_rd(8'h0f) |=> !rdata_out[7] && rdata_out[3] == $past(first_alarm_flag_out))
      else $error("first day register flag bit wrong");
   chk_day1_flag: assert property (s_rd(8'h16) |=> !rdata_out[7] && rdata_out[3] == $past(second_alarm_flag_out))
      else $error("second day register flag bit wrong");
   chk_month_pad: assert property (s_rd(8'h11) |=> rdata_out[7:5] == 3'h0)
      else $error("month match upper bits not zero");
   chk_unmapped_zero: assert property (unm |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule : rtc_alarm_regs_chk

bind rtc_alarm_regs rtc_alarm_regs_chk i_rtc_alarm_regs_chk (.*);

/* File: tb/rtc_alarm_regs_tb.sv */
// self-checking bench for the alarm and time-stamp registers
// assumes host_model drives the bus and this module drives the calendar
`timescale 1ns/1ps
module rtc_alarm_regs_tb;
   logic       clk_sys_in, rst_in, wr, rd, rvalid, stk, ttk, fail, f0, f1;
   logic [7:0] addr, wdata, rdata, sub, sec, min, hour, date, month, d;
   logic [1:0] en;
   logic [2:0] wday, c;
   int         fails, n_tests;
   logic [7:0] ra [13] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h1a, 8'h1b, 8'h05, 8'h20};
   logic [7:0] rm [13] = '{8'h77, 8'h3f, 8'h1f, 8'hff, 8'h7f, 8'h7f, 8'h77, 8'h3f, 8'h7f, 8'h3f, 8'hff, 8'h00, 8'h00};
   logic [7:0] se [8] = '{8'h45, 8'h48, 8'h15, 8'h66, 8'h46, 8'h09, 8'h16, 8'h87};
   logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   always #50 clk_sys_in = ~clk_sys_in;
   rtc_alarm_regs i_rtc_alarm_regs (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr),
      .wr_in(wr), .wdata_in(wdata), .rd_in(rd), .rdata_out(rdata), .rvalid_out(rvalid), .alarm_enable_field_in(en),
      .cal_subsec_in(sub), .cal_sec_in(sec), .cal_min_in(min), .cal_hour_in(hour), .cal_wday_in(wday),
      .cal_date_in(date), .cal_month_in(month), .subsec_tick_in(stk), .sec_tick_in(ttk), .supply_fail_in(fail),
      .first_alarm_flag_out(f0), .second_alarm_flag_out(f1));
   host_model i_host_model (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
      .wr_out(wr), .wdata_out(wdata), .rd_out(rd));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      i_host_model.read_reg(a, d);
      check(d, e);
   endtask : rc
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      i_host_model.write_reg(a, v);
   endtask : wr_reg
   // extra edge so the flag has landed
   task automatic pulse(input logic s0, input logic s1);
      @(posedge clk_sys_in);
      ttk <= s0;
      stk <= s1;
      @(posedge clk_sys_in);
      ttk <= 1'b0;
      stk <= 1'b0;
      @(posedge clk_sys_in);
      #1;
   endtask : pulse
   // h=1: compared fields match, rest differ; h=0: reverse
   task automatic set_live(input logic [2:0] k, input logic h);
      @(posedge clk_sys_in);
      sec <= ((k == 3'h0 || k == 3'h7) == h) ? 8'h30 : 8'h00;
      min <= ((k == 3'h1 || k == 3'h7) == h) ? 8'h45 : 8'h00;
      hour <= ((k == 3'h2 || k == 3'h7) == h) ? 8'h08 : 8'h00;
      wday <= ((k == 3'h3 || k == 3'h7) == h) ? 3'h3 : 3'h5;
      date <= ((k == 3'h4 || k == 3'h7) == h) ? 8'h15 : 8'h01;
      month <= ((k == 3'h7) == h) ? 8'h06 : 8'h01;
   endtask : set_live
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   initial begin
      #9000000;
      fails++;
      test_done();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      clk_sys_in = 1'b0;
      rst_in = 1'b1;
      {sub, sec, min, hour, date, month, stk, ttk, fail, en, wday} = '0;
      fails = 0;
      n_tests = 0;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 13; i++) begin
         rc(ra[i], 8'h00);
         wr_reg(ra[i], 8'hff);
         rc(ra[i], rm[i]);
      end
      $display("register map done");
      wr_reg(8'h0c, 8'h30);
      wr_reg(8'h0d, 8'h45);
      wr_reg(8'h0e, 8'h08);
      wr_reg(8'h10, 8'h15);
      wr_reg(8'h11, 8'h06);
      en <= 2'h1;
      for (int k = 0; k < 6; k++) begin
         c = codes[k];
         wr_reg(8'h0f, {1'b0, c, 4'h3});
         set_live(c, 1'b1);
         pulse(1'b1, 1'b0);
         check({7'h00, f0}, 8'h01);
         wr_reg(8'h0f, {1'b0, c, 4'hb});
         set_live(c, 1'b0);
         pulse(1'b1, 1'b0);
         rc(8'h0f, {1'b0, c, 4'hb});
         wr_reg(8'h0f, {1'b0, c, 4'h3});
         pulse(1'b1, 1'b0);
         check({7'h00, f0}, 8'h00);
      end
      set_live(3'h2, 1'b1);
      hour <= 8'h68;
      wr_reg(8'h0f, 8'h23);
      pulse(1'b1, 1'b0);
      check({7'h00, f0}, 8'h00);
      hour <= 8'h48;
      pulse(1'b1, 1'b0);
      check({7'h00, f0}, 8'h01);
      rc(8'h0e, 8'h48);
      $display("alarm codes done");
      set_live(3'h0, 1'b1);
      sub <= 8'h57;
      wr_reg(8'h12, 8'h57);
      wr_reg(8'h13, 8'h30);
      for (int e = 0; e < 4; e++) begin
         wr_reg(8'h0f, 8'h03);
         wr_reg(8'h16, 8'h03);
         en <= e[1:0];
         pulse(1'b1, 1'b1);
         check({6'h00, f1, f0}, e[7:0]);
      end
      rc(8'h16, 8'h0b);
      wr_reg(8'h16, 8'h03);
      sub <= 8'h58;
      pulse(1'b1, 1'b1);
      check({6'h00, f1, f0}, 8'h01);
      $display("enables done");
      min <= 8'h45;
      hour <= 8'h48;
      date <= 8'h15;
      month <= 8'h06;
      wday <= 3'h3;
      @(posedge clk_sys_in);
      fail <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      {min, hour, date, month, wday} <= {8'h46, 8'h09, 8'h16, 8'h07, 3'h4};
      repeat (3) @(posedge clk_sys_in);
      fail <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      {min, hour} <= {8'h59, 8'h11};
      for (int i = 0; i < 8; i++) begin
         rc(8'h18 + i[7:0], se[i]);
      end
      $display("time stamps done");
      test_done();
   end
endmodule : rtc_alarm_regs_tb
